// >>> asc_top.sv
// converter sequence control: register slave, sequencer, result and dma/irq events
// =====================================
// Notes on behaviour
// - channels 0-7 pins, 8-11 pairs, 12+ internal
// - select below 8 converts 0 up to it
// - select 8-11 converts pairs from 8 upward
// - select 12 or more converts that channel only
// - sequences skip channels whose pins are not analog
// - single write converts now, else after sequence
// - done flag set on finish, cleared reading high
// - start bit starts idle sequence, cleared at end
// - four triggers: pin edge, free, timer, bit
// - single register uses sequence field layout
// - results are two's complement
// - fourteen-bit result left aligned in bytes
// - select readback shows current, then last plus one (select 12 or more: last)
// - result bytes hold the conversion that just finished
// - decimation rate sets resolution 7 to 12
// - trigger codes 00 pin, 01 free, 10 timer, 11 bit
// - interrupt only for single conversions
// - dma triggers only for sequence conversions
// - conversion lasts rate plus 16 sample periods
`default_nettype none
module asc_top
  import asc_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES
) (
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic [4:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  input  wire logic [3:0]    avs_byteenable_i,
  output logic [31:0]        avs_readdata_o,
  output logic               avs_waitrequest_o,
  input  wire logic          ext_trig_pin_i,
  input  wire logic          timer_cmp_i,
  input  wire logic [13:0]   conv_data_i,
  output var asc_cfg_t       conv_cfg_o,
  output logic               conv_busy_o,
  output logic [7:0]         dma_chan_o,
  output logic               dma_any_o,
  output logic               irq_o
);
  // =====================================
  // bus slave
  asc_ctl1_t        ctl1;
  asc_cfg_t         seq_cfg;
  asc_cfg_t         single_cfg;
  logic [3:0]       sch_view;
  logic [7:0]       analog_pin_config;
  logic [RES_W-1:0] result;
  logic             single_pend;
  logic [2:0]       idx;
  logic             acc;
  logic             wr_en;
  logic             rd_hi;
  logic [7:0]       rd_mux;

  assign idx   = avs_address_i[IDX_LSB +: 3];
  assign acc   = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  assign wr_en = acc & avs_write_i & avs_byteenable_i[0];
  assign rd_hi = acc & avs_read_i & (idx == IDX_RES_HI);

  always_comb begin
    unique case (idx)
      IDX_CTL1:   rd_mux = ctl1;
      IDX_SEQ:    rd_mux = {seq_cfg.ref_sel, seq_cfg.dec_sel, sch_view};
      IDX_SINGLE: rd_mux = single_cfg;
      IDX_RES_LO: rd_mux = {result[0 +: 8-LO_PAD], LO_PAD'(0)};
      IDX_RES_HI: rd_mux = result[RES_W-1 -: 8];
      IDX_ANALOG_PIN_CONFIG:  rd_mux = analog_pin_config;
      default:    rd_mux = 8'h00;
    endcase
  end

  // one wait cycle per access; read data is loaded while waitrequest is high
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      avs_waitrequest_o <= ~(avs_waitrequest_o & (avs_read_i | avs_write_i));
      if (avs_waitrequest_o & avs_read_i) begin
        avs_readdata_o <= {24'h0, rd_mux};
      end
    end
  end

  // =====================================
  // sequencer
  asc_state_t       state;
  logic [4:0]       cur_ch;
  logic             is_single;
  logic [CNT_W-1:0] cnt;
  logic             pin_s1;
  logic             pin_s2;
  logic             pin_s3;
  logic             trig;
  logic [3:0]       first_ch;
  logic             conv_end;
  logic             seq_done;

  function automatic logic [CNT_W-1:0] conv_len(input logic [1:0] d);
    return CNT_W'((dec_rate(d) + CONV_OVERHEAD) * SAMPLE_CYC - 1);
  endfunction

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= ext_trig_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  always_comb begin
    unique case (ctl1.start_event_select)
      START_EVENT_SELECT_PIN:   trig = pin_s2 & ~pin_s3;
      START_EVENT_SELECT_FREE:  trig = 1'b1;
      START_EVENT_SELECT_TIMER: trig = timer_cmp_i;
      START_EVENT_SELECT_BIT:   trig = ctl1.st;
    endcase
  end

  always_comb begin
    if (seq_cfg.chan < CH_DIFF_FIRST) begin
      first_ch = CH_SE_FIRST;
    end else if (seq_cfg.chan < CH_FIRST_INTERNAL) begin
      first_ch = CH_DIFF_FIRST;
    end else begin
      first_ch = seq_cfg.chan;
    end
  end

  assign conv_end = (state == S_CONV) && (cnt == '0);
  assign seq_done = (state == S_SCAN) && (cur_ch > {1'b0, seq_cfg.chan});

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state       <= S_IDLE;
      cur_ch      <= '0;
      is_single   <= 1'b0;
      cnt         <= '0;
      conv_cfg_o  <= '0;
      conv_busy_o <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (single_pend) begin
            is_single   <= 1'b1;
            conv_cfg_o  <= single_cfg;
            cnt         <= conv_len(single_cfg.dec_sel);
            state       <= S_CONV;
            conv_busy_o <= 1'b1;
          end else if (trig) begin
            is_single <= 1'b0;
            cur_ch    <= {1'b0, first_ch};
            state     <= S_SCAN;
          end
        end
        S_SCAN: begin
          if (seq_done) begin
            state <= S_IDLE;
          end else if (chan_included(cur_ch[3:0], analog_pin_config)) begin
            conv_cfg_o  <= {seq_cfg.ref_sel, seq_cfg.dec_sel, cur_ch[3:0]};
            cnt         <= conv_len(seq_cfg.dec_sel);
            state       <= S_CONV;
            conv_busy_o <= 1'b1;
          end else begin
            cur_ch <= cur_ch + 5'h1;
          end
        end
        S_CONV: begin
          if (cnt != '0) begin
            cnt <= cnt - CNT_W'(1);
          end else begin
            conv_busy_o <= 1'b0;
            if (is_single) begin
              state <= S_IDLE;
            end else begin
              cur_ch <= cur_ch + 5'h1;
              state  <= S_SCAN;
            end
          end
        end
      endcase
    end
  end

  // =====================================
  // registers written by software
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl1.eoc   <= CTL1_RST[7];
      ctl1.st    <= CTL1_RST[6];
      ctl1.start_event_select <= CTL1_RST[5:4];
      ctl1.misc  <= CTL1_RST[3:0];
    end else begin
      if (wr_en && idx == IDX_CTL1) begin
        ctl1.start_event_select <= avs_writedata_i[5:4];
        ctl1.misc  <= avs_writedata_i[3:0];
      end
      // a write of one in the ending cycle still wins
      if (wr_en && idx == IDX_CTL1 && avs_writedata_i[6]) begin
        ctl1.st <= 1'b1;
      end else if (seq_done) begin
        ctl1.st <= 1'b0;
      end
      // the done flag lives here so the whole control word has one writer
      if (conv_end) begin
        ctl1.eoc <= 1'b1;
      end else if (rd_hi) begin
        ctl1.eoc <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_cfg  <= SEQ_RST;
      sch_view <= SEQ_RST[3:0];
    end else begin
      if (wr_en && idx == IDX_SEQ) begin
        seq_cfg  <= avs_writedata_i[7:0];
        sch_view <= avs_writedata_i[3:0];
      end else if (state == S_SCAN && !seq_done && chan_included(cur_ch[3:0], analog_pin_config)) begin
        sch_view <= cur_ch[3:0];
      end else if (seq_done) begin
        sch_view <= (seq_cfg.chan < CH_FIRST_INTERNAL) ? seq_cfg.chan + 4'h1 : seq_cfg.chan;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      single_cfg  <= SINGLE_RST;
      single_pend <= 1'b0;
    end else begin
      if (wr_en && idx == IDX_SINGLE) begin
        single_cfg  <= avs_writedata_i[7:0];
        single_pend <= 1'b1;
      end else if (state == S_IDLE) begin
        single_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_pin_config <= ANALOG_PIN_CONFIG_RST;
    end else if (wr_en && idx == IDX_ANALOG_PIN_CONFIG) begin
      analog_pin_config <= avs_writedata_i[7:0];
    end
  end

  // =====================================
  // result and dma/irq events
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result <= '0;
    end else if (conv_end) begin
      // two's complement sample kept as is, low bits cut to resolution
      result <= conv_data_i & res_mask(conv_cfg_o.dec_sel);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o      <= 1'b0;
      dma_any_o  <= 1'b0;
      dma_chan_o <= 8'h00;
    end else begin
      irq_o     <= conv_end & is_single;
      dma_any_o <= conv_end & ~is_single;
      dma_chan_o <= (conv_end && !is_single && conv_cfg_o.chan < CH_DIFF_FIRST)
                    ? 8'h01 << conv_cfg_o.chan[2:0] : 8'h00;
    end
  end

  // =====================================
  // assertions
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_conv_finish;
    state == S_CONV && cnt == '0;
  endsequence
  sequence s_conv_begin;
    state != S_CONV ##1 state == S_CONV;
  endsequence

  property p_irq_single;
    s_conv_finish and is_single |=> irq_o && !dma_any_o && dma_chan_o == 8'h00;
  endproperty
  a_irq_single: assert property (p_irq_single) else $error("single end gave no irq");

  property p_dma_seq;
    s_conv_finish and !is_single |=> dma_any_o && !irq_o;
  endproperty
  a_dma_seq: assert property (p_dma_seq) else $error("sequence end gave no dma");

  property p_eoc_set;
    s_conv_finish |=> ctl1.eoc;
  endproperty
  a_eoc_set: assert property (p_eoc_set) else $error("done flag not set");

  property p_eoc_clear;
    rd_hi && !conv_end |=> !ctl1.eoc;
  endproperty
  a_eoc_clear: assert property (p_eoc_clear) else $error("done flag not cleared");

  property p_st_clear;
    seq_done && !(wr_en && idx == IDX_CTL1) |=> !ctl1.st && state == S_IDLE;
  endproperty
  a_st_clear: assert property (p_st_clear) else $error("start bit not cleared");

  property p_conv_len;
    s_conv_begin |-> cnt == conv_len(conv_cfg_o.dec_sel) ##1 cnt == $past(cnt) - CNT_W'(1);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_skip;
    s_conv_begin ##0 !is_single |-> chan_included(conv_cfg_o.chan, $past(analog_pin_config));
  endproperty
  a_skip: assert property (p_skip) else $error("disabled channel converted");

  property p_defer;
    s_conv_begin ##0 is_single |-> $past(state, 1) == S_IDLE;
  endproperty
  a_defer: assert property (p_defer) else $error("single started inside sequence");

  property p_view_end;
    seq_done && seq_cfg.chan < CH_FIRST_INTERNAL && !wr_en |=> sch_view == $past(seq_cfg.chan) + 4'h1;
  endproperty
  a_view_end: assert property (p_view_end) else $error("select readback wrong");

  property p_res_mask;
    conv_end |=> (result & ~res_mask(conv_cfg_o.dec_sel)) == '0;
  endproperty
  a_res_mask: assert property (p_res_mask) else $error("result exceeds resolution");

  property p_lo_pad;
    !avs_waitrequest_o && avs_read_i && idx == IDX_RES_LO |-> avs_readdata_o[1:0] == 2'h0;
  endproperty
  a_lo_pad: assert property (p_lo_pad) else $error("low byte pad not zero");
endmodule
`default_nettype wire

// >>> asc_pkg.sv
// constants, types and helpers for the converter sequence control
`default_nettype none
package asc_pkg;
  // =====================================
  // register word indices (byte address = 4 * index)
  localparam logic [2:0] IDX_CTL1   = 3'h0;
  localparam logic [2:0] IDX_SEQ    = 3'h1;
  localparam logic [2:0] IDX_SINGLE = 3'h2;
  localparam logic [2:0] IDX_RES_LO = 3'h3;
  localparam logic [2:0] IDX_RES_HI = 3'h4;
  localparam logic [2:0] IDX_ANALOG_PIN_CONFIG  = 3'h5;
  localparam int unsigned IDX_LSB   = 2;
  // =====================================
  // reset values
  localparam logic [7:0] CTL1_RST   = 8'h33;
  localparam logic [7:0] SEQ_RST    = 8'h10;
  localparam logic [7:0] SINGLE_RST = 8'h00;
  localparam logic [7:0] ANALOG_PIN_CONFIG_RST  = 8'h00;
  // =====================================
  // channel numbering: 0-7 pins, 8-11 pairs, 12 gnd, 13 rsvd, 14 temp, 15 supply/3
  localparam logic [3:0] CH_DIFF_FIRST     = 4'h8;
  localparam logic [3:0] CH_FIRST_INTERNAL = 4'hc;
  localparam logic [3:0] CH_SE_FIRST       = 4'h0;
  localparam int unsigned RES_W  = 14;
  localparam int unsigned LO_PAD = 2;
  // start event encodings
  localparam logic [1:0] START_EVENT_SELECT_PIN   = 2'h0;
  localparam logic [1:0] START_EVENT_SELECT_FREE  = 2'h1;
  localparam logic [1:0] START_EVENT_SELECT_TIMER = 2'h2;
  localparam logic [1:0] START_EVENT_SELECT_BIT   = 2'h3;
  // =====================================
  // timing: sample period rounded up to whole clocks
  localparam int unsigned SAMPLE_PERIOD_PS = 250000;
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned SAMPLE_CYCLES    = (SAMPLE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CONV_OVERHEAD    = 16;
  localparam int unsigned CNT_W            = 20;
  localparam logic [9:0] DEC_RATE0 = 10'h040;
  localparam logic [9:0] DEC_RATE1 = 10'h080;
  localparam logic [9:0] DEC_RATE2 = 10'h100;
  localparam logic [9:0] DEC_RATE3 = 10'h200;
  localparam int unsigned RES_BITS0 = 7;
  localparam int unsigned RES_BITS1 = 9;
  localparam int unsigned RES_BITS2 = 10;
  localparam int unsigned RES_BITS3 = 12;
  // =====================================
  typedef struct packed {
    logic       eoc;
    logic       st;
    logic [1:0] start_event_select;
    logic [3:0] misc;
  } asc_ctl1_t;
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [1:0] dec_sel;
    logic [3:0] chan;
  } asc_cfg_t;
  typedef enum logic [1:0] {S_IDLE, S_SCAN, S_CONV} asc_state_t;
  // =====================================
  function automatic logic chan_included(input logic [3:0] ch, input logic [7:0] pins);
    if (ch < CH_DIFF_FIRST) return pins[ch[2:0]];
    if (ch < CH_FIRST_INTERNAL) return pins[{ch[1:0], 1'b0}] & pins[{ch[1:0], 1'b1}];
    return 1'b1;
  endfunction
  function automatic logic [9:0] dec_rate(input logic [1:0] d);
    unique case (d)
      2'h0: return DEC_RATE0;
      2'h1: return DEC_RATE1;
      2'h2: return DEC_RATE2;
      2'h3: return DEC_RATE3;
    endcase
  endfunction
  function automatic logic [RES_W-1:0] res_mask(input logic [1:0] d);
    int unsigned b;
    unique case (d)
      2'h0: b = RES_BITS0;
      2'h1: b = RES_BITS1;
      2'h2: b = RES_BITS2;
      2'h3: b = RES_BITS3;
    endcase
    return ~((RES_W'(1) << (RES_W - b)) - RES_W'(1));
  endfunction
endpackage
`default_nettype wire

// >>> asc_far_end.sv
// far-side model: analog front end feeding samples, dma and irq event collector
`default_nettype none
module asc_far_end
  import asc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire asc_cfg_t   cfg_i,
  input  wire logic       busy_i,
  input  wire logic [7:0] dma_chan_i,
  input  wire logic       dma_any_i,
  input  wire logic       irq_i,
  output logic [13:0]     data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] log[$];
  logic       flip;
  logic [7:0] hot;
  // =====================================
  // sample carries its channel so a stale result shows; top bit set from channel 8 up
  assign data_o = busy_i ? {cfg_i.chan, 5'h17, 5'h00} : {14{flip}};
  assign hot = (dma_any_i && cfg_i.chan < 4'h8) ? 8'h01 << cfg_i.chan : 8'h00;
  // idle line keeps toggling so a sample taken out of a conversion never looks plausible
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) flip <= 1'b0;
    else flip <= ~flip;
  end
  // entry: {irq, any, per-channel trigger as expected, 0, channel}
  always @(posedge clk_i) begin
    if (rst_n_i && (irq_i || dma_any_i || dma_chan_i != 8'h00))
      log.push_back({irq_i, dma_any_i, dma_chan_i == hot, 1'b0, cfg_i.chan});
  end
endmodule
`default_nettype wire

// >>> adc_sequence_control_test.sv
// self-checking bench: register access, single and sequence conversions, start events
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module adc_sequence_control_test
  import asc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         SC     = 1;
  localparam logic [4:0] A_CTL  = {IDX_CTL1, 2'b00};
  localparam logic [4:0] A_SEQ  = {IDX_SEQ, 2'b00};
  localparam logic [4:0] A_SGL  = {IDX_SINGLE, 2'b00};
  localparam logic [4:0] A_LO   = {IDX_RES_LO, 2'b00};
  localparam logic [4:0] A_HI   = {IDX_RES_HI, 2'b00};
  localparam logic [4:0] A_PINS = 5'h14;
  localparam logic [4:0] A_NONE = 5'h18;
  logic        core_clk, rst_n, avs_read, avs_write, ext_pin, timer_cmp;
  logic        avs_waitrequest, conv_busy, dma_any, irq;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [13:0] conv_data;
  asc_cfg_t    conv_cfg;
  logic [7:0]  dma_chan, q;
  int          n_mismatch = 0, check_count = 0, cycles = 0, busy_cycles = 0, n;
  logic [4:0]  ra[6] = '{A_CTL, A_SEQ, A_SGL, A_LO, A_HI, A_PINS};
  logic [7:0]  rv[6] = '{CTL1_RST, SEQ_RST, SINGLE_RST, 8'h00, 8'h00, 8'h00};

  asc_top #(.SAMPLE_CYC(SC)) asc_top_inst (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_byteenable),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .ext_trig_pin_i(ext_pin),
    .timer_cmp_i(timer_cmp), .conv_data_i(conv_data), .conv_cfg_o(conv_cfg), .conv_busy_o(conv_busy),
    .dma_chan_o(dma_chan), .dma_any_o(dma_any), .irq_o(irq));
  asc_far_end asc_far_end_inst (
    .clk_i(core_clk), .rst_n_i(rst_n), .cfg_i(conv_cfg), .busy_i(conv_busy), .dma_chan_i(dma_chan),
    .dma_any_i(dma_any), .irq_i(irq), .data_o(conv_data));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (conv_busy === 1'b1) busy_cycles++;
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // =====================================
  // bus access: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    // no limit here; only the bench timeout ends a wait that never sees waitrequest low
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'h1);
    `CHK(nm, e, q)
  endtask
  // wait for k events and an idle converter, then for the start bit to drop
  task automatic wait_ev(input int k);
    n = 0;
    while ((asc_far_end_inst.log.size() < k || conv_busy !== 1'b0) && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 4000) n_mismatch++;
    n = 0;
    do begin
      bus(1'b0, A_CTL, 8'h00, 4'h1);
      n++;
    end while (q[6] !== 1'b0 && n < 20);
  endtask
  task automatic cmp_log(input logic [7:0] e[$]);
    `CHK("event count", e.size(), asc_far_end_inst.log.size())
    foreach (e[i]) if (i < asc_far_end_inst.log.size()) `CHK("event", e[i], asc_far_end_inst.log[i])
    asc_far_end_inst.log.delete();
  endtask
  task automatic pulse(input logic pin);
    if (pin) ext_pin <= 1'b1;
    else timer_cmp <= 1'b1;
    repeat (pin ? 4 : 1) @(posedge core_clk);
    ext_pin <= 1'b0;
    timer_cmp <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // =====================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, ext_pin, timer_cmp} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    foreach (ra[i]) rchk("reset", ra[i], rv[i]);
    wr(A_NONE, 8'h5a);
    rchk("unmapped", A_NONE, 8'h00);
    bus(1'b1, A_PINS, 8'hff, 4'h0);
    rchk("byte enable", A_PINS, 8'h00);
    // single conversion of pair 11 with decimation code 1
    busy_cycles = 0;
    wr(A_SGL, 8'hdb);
    // the configuration is launched at the edge the task returns on; look half a cycle later
    @(negedge core_clk);
    `CHK("cfg", 8'hdb, conv_cfg)
    @(posedge core_clk);
    wait_ev(1);
    `CHK("busy", (int'(DEC_RATE1) + CONV_OVERHEAD) * SC, busy_cycles)
    cmp_log('{8'hab});
    rchk("done", A_CTL, 8'hb3);
    rchk("low", A_LO, 8'h80);
    rchk("high", A_HI, 8'hbb);
    rchk("done clr", A_CTL, 8'h33);
    // single of pin 5 at decimation code 0: seven-bit result, shorter conversion
    busy_cycles = 0;
    wr(A_SGL, 8'h05);
    wait_ev(1);
    `CHK("busy7", (int'(DEC_RATE0) + CONV_OVERHEAD) * SC, busy_cycles)
    cmp_log('{8'ha5});
    rchk("low7", A_LO, 8'h00);
    rchk("high7", A_HI, 8'h5a);
    // start-bit sequence up to 3 with pin 2 not analog
    wr(A_PINS, 8'h0b);
    wr(A_SEQ, 8'h13);
    wr(A_CTL, 8'h73);
    wait_ev(3);
    cmp_log('{8'h60, 8'h61, 8'h63});
    rchk("start clr", A_CTL, 8'hb3);
    rchk("readback", A_SEQ, 8'h14);
    rchk("last high", A_HI, 8'h3b);
    // pair sequence up to 10 with pair 9 missing, single queued behind it
    wr(A_PINS, 8'h33);
    wr(A_SEQ, 8'h1a);
    wr(A_CTL, 8'h73);
    wr(A_SGL, 8'h15);
    wait_ev(3);
    cmp_log('{8'h68, 8'h6a, 8'ha5});
    rchk("readback", A_SEQ, 8'h1b);
    // internal channel under pin, timer and free start events; pin and timer ignored while start bit selected
    wr(A_SEQ, 8'h1e);
    pulse(1'b1);
    pulse(1'b0);
    wr(A_CTL, 8'h03);
    pulse(1'b1);
    wait_ev(1);
    wr(A_CTL, 8'h23);
    pulse(1'b0);
    wait_ev(2);
    wr(A_CTL, 8'h13);
    wr(A_CTL, 8'h33);
    wait_ev(3);
    cmp_log('{8'h6e, 8'h6e, 8'h6e});
    rchk("readback", A_SEQ, 8'h1e);
    report_and_stop();
  end
endmodule
`default_nettype wire
